// file: dv/lcf_assertions.sv
// port checks of the logic cell front end
`timescale 1ns/1ps
`default_nettype none
module lcf_chk (
   // clock and reset
   input wire logic       clk,
   input wire logic       rst,
   // register port
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata,
   // lines
   input wire logic [3:0] cell_ext_pin,
   input wire logic [3:0] gate_out,
   input wire logic [3:0] data_line,
   input wire logic       cell_enable,
   input wire logic [2:0] cell_mode
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_ctrl_wr; wr && addr == 4'h0; endsequence
   sequence s_pin_wr; wr && addr == 4'h2 && wdata[5:0] < 6'h04; endsequence
   sequence s_rsvd_wr;
      wr && addr == 4'h2 && (wdata[5:0] inside {6'h06, 6'h07, [6'h29:6'h3F]});
   endsequence
   a_ctrl_reset: assert property ($fell(rst) |-> !cell_enable && cell_mode == 3'h0)
      else $error("control not cleared");
   a_ctrl_write: assert property (s_ctrl_wr |=> {cell_enable, cell_mode} ==
      {$past(wdata[7]), $past(wdata[2:0])}) else $error("control write lost");
   a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
      else $error("read data outside slot");
   a_lines_read: assert property (rd && addr == 4'hB |=> rdata == {4'h0, $past(data_line)})
      else $error("line readback wrong");
   a_status_read: assert property (rd && addr == 4'hA |=> rdata[3:0] == $past(gate_out))
      else $error("status readback wrong");
   a_unmapped_read: assert property (rd && addr > 4'hC |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_rsvd_zero: assert property (s_rsvd_wr |=> data_line[0] == 1'b0)
      else $error("reserved code not zero");
   a_pin_route: assert property (s_pin_wr |=> data_line[0] == cell_ext_pin[$past(wdata[1:0])])
      else $error("pin routing wrong");
endmodule // lcf_chk
bind logic_cell_front lcf_chk chk_u (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
   .cell_ext_pin, .gate_out, .data_line, .cell_enable, .cell_mode);
`default_nettype wire

// file: dv/src_model.sv
// candidate source model: pins, cell outputs, peripheral lines
`timescale 1ns/1ps
`default_nettype none
module src_model (
   // candidates by select code
   input  wire logic [40:0] cand,
   // to the cell
   output logic      [3:0]  pins,
   output logic             c1,
   output logic             c2,
   output logic      [32:0] per
);
   assign pins = cand[3:0];
   assign c1   = cand[4];
   assign c2   = cand[5];
   assign per  = cand[40:8];
endmodule // src_model
`default_nettype wire

// file: dv/testbench.sv
// self-checking bench of the logic cell front end
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import logic_cell_pkg::*;
   logic        clk, rst, wr, rd, c1, c2, cell_enable, v;
   cell_addr_t  addr;
   cell_byte_t  wdata, rdata;
   logic [40:0] cand;
   logic [32:0] per;
   logic [3:0]  pins, gate_out, data_line, pol, e;
   logic [2:0]  cell_mode;
   logic [15:0] g;
   int          n_errors, n_tests, c, m, t, i;
   logic [15:0] tab [8] = '{16'h5501, 16'h5500, 16'hAA01, 16'hAA00,
                            16'h0000, 16'h0001, 16'h0301, 16'h9601};
   src_model src_u (.cand, .pins, .c1, .c2, .per);
   logic_cell_front dut_u (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .cell_ext_pin(pins),
      .cell1_output(c1), .cell2_output(c2), .periph_src(per), .gate_out, .data_line,
      .cell_enable, .cell_mode);
   task check(input logic [7:0] s, input logic [7:0] x);
      n_tests++;
      if (s !== x) begin
         n_errors++;
         $display("[FAIL] %0t seen %h wanted %h", $time, s, x);
      end
   endtask
   task wr_reg(input cell_addr_t a, input cell_byte_t d);
      @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
      @(posedge clk) wr <= 1'b0;
      #1;
   endtask
   task rd_chk(input cell_addr_t a, input cell_byte_t x);
      @(posedge clk) begin addr <= a; rd <= 1'b1; end
      @(posedge clk) rd <= 1'b0;
      #1 check(rdata, x);
   endtask
   function automatic logic gx(input logic [15:0] q, input logic [3:0] d);
      logic a;
      a = 1'b1;
      for (int k = 0; k < 4; k++) a = a & (q[8+2*k] ? d[k] : 1'b1) & (q[9+2*k] ? ~d[k] : 1'b1);
      return q[0] ? a : ~a;
   endfunction
   task final_report;
      if (n_errors == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      #100000;
      n_errors++;
      final_report;
   end
   initial begin
      {rst, wr, rd, addr, wdata, cand, n_errors, n_tests} = '0;
      rst = 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      wr_reg(4'h0, 8'hFF);
      rd_chk(4'h0, 8'h87);
      wr_reg(4'h2, 8'h05);
      @(posedge clk) rst <= 1'b1;
      @(posedge clk) rst <= 1'b0;
      #1 check({cell_enable, 4'h0, cell_mode}, 8'h00);
      rd_chk(4'h2, 8'h05);
      for (m = 0; m < 4; m++)
         for (c = 0; c < 64; c++) begin
            v = c < 41 && c != 6 && c != 7;
            @(posedge clk) cand <= v ? 41'h1 << c : '1;
            wr_reg(cell_addr_t'(2 + m), c[7:0]);
            check({7'h0, data_line[m]}, {7'h0, v});
         end
      rd_chk(4'hC, 8'h0F);
      wr_reg(4'hC, 8'h0F);
      rd_chk(4'hC, 8'h00);
      for (m = 0; m < 4; m++) wr_reg(cell_addr_t'(2 + m), m[7:0]);
      for (t = 0; t < 8; t++) begin
         for (m = 0; m < 4; m++) begin
            g = tab[(t + m) % 8];
            pol[m] = g[0];
            wr_reg(cell_addr_t'(6 + m), g[15:8]);
         end
         wr_reg(4'h1, {4'h0, pol});
         for (i = 0; i < 16; i++) begin
            @(posedge clk) cand <= {37'h0, i[3:0]};
            #1;
            for (m = 0; m < 4; m++) e[m] = gx(tab[(t + m) % 8], i[3:0]);
            check({4'h0, gate_out}, {4'h0, e});
         end
         rd_chk(4'hA, {4'hF, e});
         rd_chk(4'hB, 8'h0F);
         rd_chk(4'h1, {4'h0, pol});
      end
      wr_reg(4'hD, 8'hFF);
      rd_chk(4'hD, 8'h00);
      final_report;
   end
endmodule // testbench
`default_nettype wire

// file: verilog/data_gate.sv
// one data gate: true/inverted enables, and-combine, output polarity
`include "logic_cell_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module data_gate
   import logic_cell_pkg::*;
(
   gate_if.gate g
);
   logic and_term;

   // even bit enables the true line, odd bit the inverted line
   always_comb begin
      and_term = 1'b1;
      for (int k = 0; k < `NUM_LINES; k++) begin
         if (g.enables[2*k])
            and_term = and_term & g.lines[k];
         if (g.enables[2*k+1])
            and_term = and_term & ~g.lines[k];
      end
   end

   // polarity high passes the and, low inverts it; no enables gives the polarity level
   assign g.result = g.polarity ? and_term : ~and_term;

endmodule // data_gate
`default_nettype wire

// file: verilog/gate_if.sv
// per-gate signals between the cell front end and one data gate
`timescale 1ns/1ps
`default_nettype none
interface gate_if;
   import logic_cell_pkg::*;
   line_vec_t    lines;
   gate_enable_t enables;
   logic         polarity;
   logic         result;
   modport front (output lines, output enables, output polarity, input result);
   modport gate  (input lines, input enables, input polarity, output result);
endinterface
`default_nettype wire

// file: verilog/logic_cell_cfg.svh
// register offsets, field positions, reset values and select codes of the logic cell front end
`ifndef LOGIC_CELL_CFG_SVH
`define LOGIC_CELL_CFG_SVH

`define CELL_ADDR_W          4
`define CELL_DATA_W          8
`define CELL_ADDR_CTRL       4'h0
`define CELL_ADDR_POL        4'h1
`define CELL_ADDR_SEL0       4'h2
`define CELL_ADDR_SEL3       4'h5
`define CELL_ADDR_GATE0      4'h6
`define CELL_ADDR_GATE3      4'h9
`define CELL_ADDR_STATUS     4'hA
`define CELL_ADDR_LINES      4'hB
`define CELL_ADDR_ERROR      4'hC

`define CTRL_RESET           8'h00
`define CTRL_EN_BIT          7
`define CTRL_MODE_HI         2
`define CTRL_MODE_LO         0
`define CTRL_MASK            8'h87

`define NUM_LINES            4
`define NUM_CANDIDATES       41
`define NUM_PERIPH           33
`define SEL_W                6
`define SEL_RSVD_LO          6'h06
`define SEL_RSVD_HI          6'h07
`define SEL_LAST             6'h28

`endif

// file: verilog/logic_cell_front.sv
// logic cell front end: input select muxes, data gates and their registers
//
// What this block does
// - four independent 41-way input multiplexers
// - six-bit select codes, pins, cells, peripherals
// - one select register per multiplexer
// - each gate takes any selected line combination
// - true or inverted per line, ANDed
// - per-gate polarity bit inverts AND result when low
// - 0x55 and 0xAA give AND/NAND, NOR/OR
// - no enables gives polarity-level constant
// - both forms of a line force the AND term to zero
// - gate enables unknown until software writes
// - four identical gates, own enable registers
// - settings writable live, effective immediately
// - gate outputs feed the logic-function stage
// - reset clears the control register, select error flags and gate-written flags
//
// The address-and-strobe port and the register offsets were decided locally.
`include "logic_cell_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module logic_cell_front
   import logic_cell_pkg::*;
(
   // clock and reset
   input  wire logic                        clk,
   input  wire logic                        rst,
   // register port
   input  wire logic [`CELL_ADDR_W-1:0]     addr,
   input  wire logic [`CELL_DATA_W-1:0]     wdata,
   input  wire logic                        wr,
   input  wire logic                        rd,
   output logic      [`CELL_DATA_W-1:0]     rdata,
   // candidate sources
   input  wire logic [`NUM_LINES-1:0]       cell_ext_pin,
   input  wire logic                        cell1_output,
   input  wire logic                        cell2_output,
   input  wire logic [`NUM_PERIPH-1:0]      periph_src,
   // to the logic-function stage
   output logic      [`NUM_LINES-1:0]       gate_out,
   output logic      [`NUM_LINES-1:0]       data_line,
   output logic                             cell_enable,
   output logic      [2:0]                  cell_mode
);

   // register state
   cell_byte_t   control;
   line_vec_t    gate_polarity;
   sel_code_t    input_select_reg [`NUM_LINES];
   gate_enable_t gate_enable_reg [`NUM_LINES];
   line_vec_t    select_error;
   line_vec_t    gate_written;
   cell_byte_t   next_rdata;
   line_vec_t    next_select_error;
   line_vec_t    raise_error;
   logic         [`NUM_CANDIDATES-1:0] candidates;
   line_vec_t    gate_result;

   // true for a code that names no signal
   function automatic logic sel_is_void(input sel_code_t code);
      sel_is_void = (code == `SEL_RSVD_LO) || (code == `SEL_RSVD_HI) ||
                    (code > `SEL_LAST);
   endfunction

   // true when an address hits entry idx of a group of four consecutive registers
   function automatic logic hit_group(input cell_addr_t a, input cell_addr_t base,
                                      input int unsigned idx);
      hit_group = (a == (base + cell_addr_t'(idx)));
   endfunction

   // one-hot select decode onto the candidate vector
   function automatic logic mux_pick(input sel_code_t code,
                                     input logic [`NUM_CANDIDATES-1:0] src);
      logic hit;
      hit = 1'b0;
      if (!sel_is_void(code))
         hit = src[code];
      mux_pick = hit;
   endfunction

   // candidate vector: pins, cell outputs, two reserved, peripherals
   always_comb begin
      candidates = '0;
      candidates[3:0] = cell_ext_pin;
      candidates[4] = cell1_output;
      candidates[5] = cell2_output;
      candidates[`NUM_CANDIDATES-1:8] = periph_src;
   end

   // control register, cleared by reset like the select error and gate-written flags
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         control <= `CTRL_RESET;
      end else if (wr && addr == `CELL_ADDR_CTRL) begin
         control <= wdata & `CTRL_MASK;
      end
   end

   // gate polarity register, kept across reset
   always_ff @(posedge clk) begin
      if (wr && addr == `CELL_ADDR_POL) begin
         gate_polarity <= wdata[`NUM_LINES-1:0];
      end
   end

   // select registers, kept across reset
   always_ff @(posedge clk) begin
      for (int i = 0; i < `NUM_LINES; i++) begin
         if (wr && hit_group(addr, `CELL_ADDR_SEL0, i)) begin
            input_select_reg[i] <= wdata[`SEL_W-1:0];
         end
      end
   end

   // gate enable registers, unknown until first written
   always_ff @(posedge clk) begin
      for (int i = 0; i < `NUM_LINES; i++) begin
         if (wr && hit_group(addr, `CELL_ADDR_GATE0, i)) begin
            gate_enable_reg[i] <= wdata;
         end
      end
   end

   // tracks which gates have been written since reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gate_written <= '0;
      end else begin
         for (int i = 0; i < `NUM_LINES; i++) begin
            if (wr && hit_group(addr, `CELL_ADDR_GATE0, i)) begin
               gate_written[i] <= 1'b1;
            end
         end
      end
   end

   // sticky flag per mux when a void code is written
   always_comb begin
      raise_error = '0;
      for (int i = 0; i < `NUM_LINES; i++) begin
         if (wr && hit_group(addr, `CELL_ADDR_SEL0, i) && sel_is_void(wdata[`SEL_W-1:0]))
            raise_error[i] = 1'b1;
      end
   end

   // write one clears; a new event in the same cycle wins
   always_comb begin
      next_select_error = select_error;
      if (wr && addr == `CELL_ADDR_ERROR)
         next_select_error = select_error & ~wdata[`NUM_LINES-1:0];
      next_select_error = next_select_error | raise_error;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         select_error <= '0;
      end else begin
         select_error <= next_select_error;
      end
   end

   // four input multiplexers, any candidate on any line
   always_comb begin
      for (int i = 0; i < `NUM_LINES; i++) begin
         data_line[i] = mux_pick(input_select_reg[i], candidates);
      end
   end

   // four identical gates behind the carrier interface
   gate_if gif [`NUM_LINES] ();

   for (genvar gi = 0; gi < `NUM_LINES; gi++) begin : g_gate
      assign gif[gi].lines = data_line;
      assign gif[gi].enables = gate_enable_reg[gi];
      assign gif[gi].polarity = gate_polarity[gi];
      assign gate_result[gi] = gif[gi].result;
      data_gate u_gate (
         .g (gif[gi])
      );
   end

   // gate results go straight to the logic-function stage
   assign gate_out = gate_result;

   // control fields
   assign cell_enable = control[`CTRL_EN_BIT];
   assign cell_mode = control[`CTRL_MODE_HI:`CTRL_MODE_LO];

   // read decode
   always_comb begin
      next_rdata = '0;
      case (addr)
         `CELL_ADDR_CTRL: begin
            next_rdata = control;
         end
         `CELL_ADDR_POL: begin
            next_rdata = {4'h0, gate_polarity};
         end
         `CELL_ADDR_STATUS: begin
            next_rdata = {gate_written, gate_result};
         end
         `CELL_ADDR_LINES: begin
            next_rdata = {4'h0, data_line};
         end
         `CELL_ADDR_ERROR: begin
            next_rdata = {4'h0, select_error};
         end
         default: begin
            for (int i = 0; i < `NUM_LINES; i++) begin
               if (hit_group(addr, `CELL_ADDR_SEL0, i))
                  next_rdata = {2'h0, input_select_reg[i]};
               if (hit_group(addr, `CELL_ADDR_GATE0, i))
                  next_rdata = gate_enable_reg[i];
            end
         end
      endcase
   end

   // read data stand the cycle after the strobe only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= 8'h00;
      end else if (rd) begin
         rdata <= next_rdata;
      end else begin
         rdata <= 8'h00;
      end
   end

endmodule // logic_cell_front
`default_nettype wire

// file: verilog/logic_cell_pkg.sv
// types shared by the logic cell front end
package logic_cell_pkg;
   typedef logic [5:0] sel_code_t;
   typedef logic [7:0] gate_enable_t;
   typedef logic [7:0] cell_byte_t;
   typedef logic [3:0] cell_addr_t;
   typedef logic [3:0] line_vec_t;
endpackage
